/* File: output_mixer_pkg.sv */
// package: register map, field layout, resets and carrier structs for the output mixer routing registers
package output_mixer_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 9;

  // register addresses
  localparam logic [7:0] SPEAKER_OUTPUT_MIX_ROUTE_ADDR  = 8'h24;
  localparam logic [7:0] LEFT_HEADPHONE_MIX_ROUTE_ADDR  = 8'h2d;
  localparam logic [7:0] RIGHT_HEADPHONE_MIX_ROUTE_ADDR = 8'h2e;
  localparam logic [7:0] LEFT_HEADPHONE_MIX_GAIN_ADDR   = 8'h2f;
  localparam logic [7:0] RIGHT_HEADPHONE_MIX_GAIN_ADDR  = 8'h30;

  // field positions
  localparam int unsigned SPK_TO_OUT_BIT = 4;
  localparam int unsigned ROUTE_A1_BIT   = 6;
  localparam int unsigned ROUTE_B1_BIT   = 4;
  localparam int unsigned ROUTE_A2_BIT   = 2;
  localparam int unsigned ROUTE_B2_BIT   = 0;
  localparam int unsigned MUTE_BIT       = 8;
  localparam int unsigned ATTEN_A1_LSB   = 6;
  localparam int unsigned ATTEN_B1_LSB   = 4;
  localparam int unsigned ATTEN_A2_LSB   = 2;
  localparam int unsigned ATTEN_B2_LSB   = 0;

  // writable bits of each register
  localparam logic [8:0] SPK_ROUTE_MASK   = 9'h010;
  localparam logic [8:0] LEFT_ROUTE_MASK  = 9'h044;
  localparam logic [8:0] RIGHT_ROUTE_MASK = 9'h055;
  localparam logic [8:0] LEFT_GAIN_MASK   = 9'h1cc;
  localparam logic [8:0] RIGHT_GAIN_MASK  = 9'h1ff;

  // reset values
  localparam logic [8:0] SPK_ROUTE_RESET   = 9'h010;
  localparam logic [8:0] LEFT_ROUTE_RESET  = 9'h000;
  localparam logic [8:0] RIGHT_ROUTE_RESET = 9'h000;
  localparam logic [8:0] LEFT_GAIN_RESET   = 9'h100;
  localparam logic [8:0] RIGHT_GAIN_RESET  = 9'h100;

  // attenuation codes
  localparam logic [1:0] ATTEN_0DB  = 2'h0;
  localparam logic [1:0] ATTEN_6DB  = 2'h1;
  localparam logic [1:0] ATTEN_9DB  = 2'h2;
  localparam logic [1:0] ATTEN_12DB = 2'h3;
  localparam logic [3:0] ATTEN_DB_0  = 4'h0;
  localparam logic [3:0] ATTEN_DB_6  = 4'h6;
  localparam logic [3:0] ATTEN_DB_9  = 4'h9;
  localparam logic [3:0] ATTEN_DB_12 = 4'hc;

  typedef struct packed {
    logic                write;
    logic                read;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } reg_req_s;

  typedef struct packed {
    logic                valid;
    logic                hit;
    logic [DATA_W-1:0]   rdata;
  } reg_rsp_s;

  // per-path analog settings; index 0=a1, 1=b1, 2=a2, 3=b2
  typedef struct packed {
    logic       mute;
    logic [3:0] routeEn;
    logic [7:0] attenCode;
    logic [15:0] attenDb;
  } mixer_ctrl_s;

endpackage

/* File: output_mixer_routing_regs.sv */
// output mixer routing register bank with decoded analog control outputs
//
// Function
// - speaker output connect bit sits at bit 4 and resets to one
// - left route bits 6 and 2 connect a1 and a2, reset zero
// - right route bits 6,4,2,0 connect a1,b1,a2,b2, reset zero
// - each headphone gain register has mute at bit 8, reset one
// - left gain attenuation fields at 7:6 (a1) and 3:2 (a2), reset zero
// - right gain attenuation fields 7:6,5:4,3:2,1:0 for a1,b1,a2,b2
// - attenuation codes decode to 0, 6, 9 and 12 dB
// - left mixer has only a1 and a2 controls, right has all four
`timescale 1ns/1ps
`default_nettype none

module output_mixer_routing_regs (
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  wire output_mixer_pkg::reg_req_s regReq,
  output var  output_mixer_pkg::reg_rsp_s regRsp,
  output logic                            spkMixerToSpkOutEn,
  output var  output_mixer_pkg::mixer_ctrl_s leftHpMixer,
  output var  output_mixer_pkg::mixer_ctrl_s rightHpMixer
);

  // ==========================================================
  // address decode
  wire selSpk   = regReq.addr == output_mixer_pkg::SPEAKER_OUTPUT_MIX_ROUTE_ADDR;
  wire selLRte  = regReq.addr == output_mixer_pkg::LEFT_HEADPHONE_MIX_ROUTE_ADDR;
  wire selRRte  = regReq.addr == output_mixer_pkg::RIGHT_HEADPHONE_MIX_ROUTE_ADDR;
  wire selLGain = regReq.addr == output_mixer_pkg::LEFT_HEADPHONE_MIX_GAIN_ADDR;
  wire selRGain = regReq.addr == output_mixer_pkg::RIGHT_HEADPHONE_MIX_GAIN_ADDR;
  wire anyHit   = selSpk | selLRte | selRRte | selLGain | selRGain;

  logic [8:0] speakerOutputMixRoute;
  logic [8:0] leftHeadphoneMixRoute;
  logic [8:0] rightHeadphoneMixRoute;
  logic [8:0] leftHeadphoneMixGain;
  logic [8:0] rightHeadphoneMixGain;

  // masking keeps unassigned bits at zero
  wire [8:0] next_speakerOutputMixRoute  = regReq.wdata & output_mixer_pkg::SPK_ROUTE_MASK;
  wire [8:0] next_leftHeadphoneMixRoute  = regReq.wdata & output_mixer_pkg::LEFT_ROUTE_MASK;
  wire [8:0] next_rightHeadphoneMixRoute = regReq.wdata & output_mixer_pkg::RIGHT_ROUTE_MASK;
  wire [8:0] next_leftHeadphoneMixGain   = regReq.wdata & output_mixer_pkg::LEFT_GAIN_MASK;
  wire [8:0] next_rightHeadphoneMixGain  = regReq.wdata & output_mixer_pkg::RIGHT_GAIN_MASK;

  wire [8:0] readMux = selSpk   ? speakerOutputMixRoute :
                       selLRte  ? leftHeadphoneMixRoute :
                       selRRte  ? rightHeadphoneMixRoute :
                       selLGain ? leftHeadphoneMixGain :
                       selRGain ? rightHeadphoneMixGain : 9'h000;

  // ==========================================================
  // register storage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      speakerOutputMixRoute  <= output_mixer_pkg::SPK_ROUTE_RESET;
      leftHeadphoneMixRoute  <= output_mixer_pkg::LEFT_ROUTE_RESET;
      rightHeadphoneMixRoute <= output_mixer_pkg::RIGHT_ROUTE_RESET;
      leftHeadphoneMixGain   <= output_mixer_pkg::LEFT_GAIN_RESET;
      rightHeadphoneMixGain  <= output_mixer_pkg::RIGHT_GAIN_RESET;
    end else if (regReq.write) begin
      if (selSpk)   speakerOutputMixRoute  <= next_speakerOutputMixRoute;
      if (selLRte)  leftHeadphoneMixRoute  <= next_leftHeadphoneMixRoute;
      if (selRRte)  rightHeadphoneMixRoute <= next_rightHeadphoneMixRoute;
      if (selLGain) leftHeadphoneMixGain   <= next_leftHeadphoneMixGain;
      if (selRGain) rightHeadphoneMixGain  <= next_rightHeadphoneMixGain;
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRsp <= '0;
    end else begin
      regRsp.valid <= regReq.read;
      regRsp.hit   <= regReq.read & anyHit;
      regRsp.rdata <= regReq.read ? readMux : 9'h000;
    end
  end

  // ==========================================================
  // decoded controls toward the analog mixers
  function automatic logic [3:0] attenDb(input logic [1:0] code);
    case (code)
      output_mixer_pkg::ATTEN_0DB:  attenDb = output_mixer_pkg::ATTEN_DB_0;
      output_mixer_pkg::ATTEN_6DB:  attenDb = output_mixer_pkg::ATTEN_DB_6;
      output_mixer_pkg::ATTEN_9DB:  attenDb = output_mixer_pkg::ATTEN_DB_9;
      default:                      attenDb = output_mixer_pkg::ATTEN_DB_12;
    endcase
  endfunction

  output_mixer_pkg::mixer_ctrl_s next_leftHpMixer;
  output_mixer_pkg::mixer_ctrl_s next_rightHpMixer;

  // path order a1,b1,a2,b2 maps to bit pairs 7:6,5:4,3:2,1:0
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_path
      localparam int unsigned LSB = 6 - 2 * p;
      assign next_leftHpMixer.routeEn[p]          = leftHeadphoneMixRoute[LSB];
      assign next_rightHpMixer.routeEn[p]         = rightHeadphoneMixRoute[LSB];
      assign next_leftHpMixer.attenCode[2*p +: 2] = leftHeadphoneMixGain[LSB +: 2];
      assign next_rightHpMixer.attenCode[2*p +: 2] = rightHeadphoneMixGain[LSB +: 2];
      assign next_leftHpMixer.attenDb[4*p +: 4]   = attenDb(leftHeadphoneMixGain[LSB +: 2]);
      assign next_rightHpMixer.attenDb[4*p +: 4]  = attenDb(rightHeadphoneMixGain[LSB +: 2]);
    end
  endgenerate
  assign next_leftHpMixer.mute  = leftHeadphoneMixGain[output_mixer_pkg::MUTE_BIT];
  assign next_rightHpMixer.mute = rightHeadphoneMixGain[output_mixer_pkg::MUTE_BIT];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      spkMixerToSpkOutEn <= output_mixer_pkg::SPK_ROUTE_RESET[output_mixer_pkg::SPK_TO_OUT_BIT];
      leftHpMixer        <= '0;
      rightHpMixer       <= '0;
      leftHpMixer.mute   <= output_mixer_pkg::LEFT_GAIN_RESET[output_mixer_pkg::MUTE_BIT];
      rightHpMixer.mute  <= output_mixer_pkg::RIGHT_GAIN_RESET[output_mixer_pkg::MUTE_BIT];
    end else begin
      spkMixerToSpkOutEn <= speakerOutputMixRoute[output_mixer_pkg::SPK_TO_OUT_BIT];
      leftHpMixer        <= next_leftHpMixer;
      rightHpMixer       <= next_rightHpMixer;
    end
  end

  // ==========================================================
  // checks
  a_spk_connect_follows: assert property (@(posedge core_clk) disable iff (!rst_b)
    regReq.write && selSpk |=> ##1 spkMixerToSpkOutEn == $past(regReq.wdata[4], 2))
    else $error("speaker connect output does not follow write");
  a_left_unused_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    (leftHeadphoneMixRoute & ~output_mixer_pkg::LEFT_ROUTE_MASK) == 9'h000
    && !leftHpMixer.routeEn[1] && !leftHpMixer.routeEn[3])
    else $error("left mixer exposes b inputs");
  a_right_route_map: assert property (@(posedge core_clk) disable iff (!rst_b)
    regReq.write && selRRte |=> ##1 rightHpMixer.routeEn == {$past(regReq.wdata[0], 2),
      $past(regReq.wdata[2], 2), $past(regReq.wdata[4], 2), $past(regReq.wdata[6], 2)})
    else $error("right route bits misplaced");
  a_left_route_map: assert property (@(posedge core_clk) disable iff (!rst_b)
    regReq.write && selLRte |=> ##1 leftHpMixer.routeEn[0] == $past(regReq.wdata[6], 2)
      && leftHpMixer.routeEn[2] == $past(regReq.wdata[2], 2))
    else $error("left route bits misplaced");
  a_mute_follows: assert property (@(posedge core_clk) disable iff (!rst_b)
    regReq.write && selLGain |=> ##1 leftHpMixer.mute == $past(regReq.wdata[8], 2))
    else $error("left mute does not follow write");
  a_right_gain_map: assert property (@(posedge core_clk) disable iff (!rst_b)
    regReq.write && selRGain |=> ##1 rightHpMixer.attenCode[1:0] == $past(regReq.wdata[7:6], 2)
      && rightHpMixer.attenCode[7:6] == $past(regReq.wdata[1:0], 2))
    else $error("right attenuation fields misplaced");
  a_left_gain_map: assert property (@(posedge core_clk) disable iff (!rst_b)
    regReq.write && selLGain |=> ##1 leftHpMixer.attenCode[5:4] == $past(regReq.wdata[3:2], 2))
    else $error("left a2 attenuation misplaced");
  a_atten_decode: assert property (@(posedge core_clk) disable iff (!rst_b)
    rightHpMixer.attenCode[1:0] == 2'h2 |-> rightHpMixer.attenDb[3:0] == 4'h9)
    else $error("attenuation decode wrong");
  a_read_unused_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    regReq.read && !anyHit |=> regRsp.valid && !regRsp.hit && regRsp.rdata == 9'h000)
    else $error("unmapped read not zero");

  // ==========================================================
  // reset state at the first edge after release, further field and bus checks
  a_reset_connect: assert property (@(posedge core_clk)
    $rose(rst_b) |-> spkMixerToSpkOutEn
      && speakerOutputMixRoute == output_mixer_pkg::SPK_ROUTE_RESET)
    else $error("speaker connect not set after reset");
  a_reset_mute: assert property (@(posedge core_clk)
    $rose(rst_b) |-> leftHpMixer.mute && rightHpMixer.mute)
    else $error("headphone mixers not muted after reset");
  a_reset_route_off: assert property (@(posedge core_clk)
    $rose(rst_b) |-> leftHpMixer.routeEn == 4'h0 && rightHpMixer.routeEn == 4'h0)
    else $error("mixer inputs connected after reset");
  a_reset_atten_zero: assert property (@(posedge core_clk)
    $rose(rst_b) |-> leftHpMixer.attenCode == 8'h00 && rightHpMixer.attenCode == 8'h00)
    else $error("attenuation not zero after reset");
  a_right_mute_follows: assert property (@(posedge core_clk) disable iff (!rst_b)
    regReq.write && selRGain |=> ##1 rightHpMixer.mute == $past(regReq.wdata[8], 2))
    else $error("right mute does not follow write");
  a_left_a1_gain: assert property (@(posedge core_clk) disable iff (!rst_b)
    regReq.write && selLGain |=> ##1 leftHpMixer.attenCode[1:0] == $past(regReq.wdata[7:6], 2))
    else $error("left a1 attenuation misplaced");
  a_right_mid_gain: assert property (@(posedge core_clk) disable iff (!rst_b)
    regReq.write && selRGain |=> ##1 rightHpMixer.attenCode[3:2] == $past(regReq.wdata[5:4], 2)
      && rightHpMixer.attenCode[5:4] == $past(regReq.wdata[3:2], 2))
    else $error("right b1 or a2 attenuation misplaced");
  a_decode_six: assert property (@(posedge core_clk) disable iff (!rst_b)
    leftHpMixer.attenCode[1:0] == 2'h1 |-> leftHpMixer.attenDb[3:0] == 4'h6)
    else $error("attenuation code one not six dB");
  a_decode_twelve: assert property (@(posedge core_clk) disable iff (!rst_b)
    rightHpMixer.attenCode[7:6] == 2'h3 |-> rightHpMixer.attenDb[15:12] == 4'hc)
    else $error("attenuation code three not twelve dB");
  a_decode_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    rightHpMixer.attenCode[5:4] == 2'h0 |-> rightHpMixer.attenDb[11:8] == 4'h0)
    else $error("attenuation code zero not zero dB");
  a_left_b_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    leftHpMixer.attenCode[3:2] == 2'h0 && leftHpMixer.attenCode[7:6] == 2'h0
    && leftHpMixer.attenDb[7:4] == 4'h0 && leftHpMixer.attenDb[15:12] == 4'h0)
    else $error("left mixer exposes b attenuation");
  a_unused_bits_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    (speakerOutputMixRoute & ~output_mixer_pkg::SPK_ROUTE_MASK) == 9'h000
    && (rightHeadphoneMixRoute & ~output_mixer_pkg::RIGHT_ROUTE_MASK) == 9'h000
    && (leftHeadphoneMixGain & ~output_mixer_pkg::LEFT_GAIN_MASK) == 9'h000)
    else $error("unassigned register bit set");
  a_unmapped_write_kept: assert property (@(posedge core_clk) disable iff (!rst_b)
    regReq.write && !anyHit |=> $stable(speakerOutputMixRoute) && $stable(leftHeadphoneMixRoute)
      && $stable(rightHeadphoneMixRoute) && $stable(leftHeadphoneMixGain)
      && $stable(rightHeadphoneMixGain))
    else $error("unmapped write changed a register");
  a_read_mapped_hit: assert property (@(posedge core_clk) disable iff (!rst_b)
    regReq.read && anyHit |=> regRsp.valid && regRsp.hit)
    else $error("mapped read not answered as hit");
  a_read_old_value: assert property (@(posedge core_clk) disable iff (!rst_b)
    regReq.read && selRGain |=> regRsp.rdata == $past(rightHeadphoneMixGain))
    else $error("right gain read back wrong");
  a_idle_no_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
    !regReq.read |=> !regRsp.valid && regRsp.rdata == 9'h000)
    else $error("answer without read request");

endmodule

`default_nettype wire

/* File: tb_top.sv */
// self-checking testbench for the output mixer routing register bank
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                          core_clk = 1'b0;
  logic                          rst_b    = 1'b0;
  output_mixer_pkg::reg_req_s    regReq   = '0;
  output_mixer_pkg::reg_rsp_s    regRsp;
  logic                          spkMixerToSpkOutEn;
  output_mixer_pkg::mixer_ctrl_s leftHpMixer;
  output_mixer_pkg::mixer_ctrl_s rightHpMixer;
  int                            n_mismatch = 0;
  int                            checked    = 0;
  int                            mdl [int];
  int                            msk [int];
  logic [31:0]                   lfsrState  = 32'hef79606a;
  logic [7:0]                    addrs [5]  = '{8'h24, 8'h2d, 8'h2e, 8'h2f, 8'h30};

  always #50 core_clk = ~core_clk;

  output_mixer_routing_regs DUT (
    .core_clk           (core_clk),
    .rst_b              (rst_b),
    .regReq             (regReq),
    .regRsp             (regRsp),
    .spkMixerToSpkOutEn (spkMixerToSpkOutEn),
    .leftHpMixer        (leftHpMixer),
    .rightHpMixer       (rightHpMixer)
  );

  // ==========================================================================
  // reference model
  function automatic logic [31:0] lfsr();
    lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    return lfsrState;
  endfunction

  task automatic mdl_reset();
    int rv [5] = '{'h010, 'h000, 'h000, 'h100, 'h100};
    int mv [5] = '{'h010, 'h044, 'h055, 'h1cc, 'h1ff};
    foreach (addrs[i]) begin
      mdl[addrs[i]] = rv[i];
      msk[addrs[i]] = mv[i];
    end
  endtask

  // path index 0=a1 1=b1 2=a2 3=b2, two register bits apart from bit 6 down
  function automatic output_mixer_pkg::mixer_ctrl_s exp_mix(int r, int g);
    output_mixer_pkg::mixer_ctrl_s m;
    int                            db [4] = '{0, 6, 9, 12};
    m.mute = g[8];
    for (int p = 0; p < 4; p++) begin
      m.routeEn[p]          = r[6-2*p];
      m.attenCode[2*p +: 2] = g[6-2*p +: 2];
      m.attenDb[4*p +: 4]   = 4'(db[g[6-2*p +: 2]]);
    end
    return m;
  endfunction

  // ==========================================================================
  // compare and drive tasks
  task automatic fail(string msg);
    n_mismatch++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  task automatic cmp_rd(logic [7:0] a);
    logic       eh;
    logic [8:0] ev;
    eh = mdl.exists(a);
    ev = eh ? 9'(mdl[a]) : 9'h000;
    checked++;
    if (regRsp !== {1'b1, eh, ev}) fail($sformatf("read %h got %h", a, regRsp));
  endtask

  task automatic cmp_out();
    checked++;
    if (spkMixerToSpkOutEn !== mdl['h24][4] || leftHpMixer !== exp_mix(mdl['h2d], mdl['h2f])
        || rightHpMixer !== exp_mix(mdl['h2e], mdl['h30])) fail("control outputs differ");
  endtask

  // one request held for exactly one rising edge; read checked before the write lands
  task automatic acc(logic w, logic r, logic [7:0] a, logic [8:0] d);
    regReq = '{write: w, read: r, addr: a, wdata: d};
    @(negedge core_clk);
    if (r) cmp_rd(a);
    if (w && mdl.exists(a)) mdl[a] = int'(d) & msk[a];
  endtask

  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] rnd;
    logic [7:0]  ad;
    mdl_reset();
    repeat (20) @(negedge core_clk);
    cmp_out();
    rst_b = 1'b1;
    @(negedge core_clk);
    foreach (addrs[i]) acc(1'b0, 1'b1, addrs[i], 9'h000);
    acc(1'b0, 1'b1, 8'h25, 9'h000);
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, 1'b0, 8'h2f, {1'b1, {4{2'(c)}}});
      acc(1'b1, 1'b0, 8'h30, {1'b0, {4{2'(c)}}});
      regReq = '0;
      @(negedge core_clk);
      cmp_out();
    end
    for (int k = 0; k < 300; k++) begin
      rnd = lfsr();
      ad  = (rnd[2:0] < 3'h5) ? addrs[rnd[2:0]] : rnd[15:8];
      acc(rnd[16], rnd[17], ad, rnd[26:18]);
      regReq = '0;
      @(negedge core_clk);
      cmp_out();
    end
    // speaker path idle: disconnect, then connect again before the path is used
    acc(1'b1, 1'b0, 8'h24, 9'h000);
    regReq = '0;
    @(negedge core_clk);
    cmp_out();
    acc(1'b1, 1'b0, 8'h24, 9'h010);
    // all four inputs into the right mixer, each path at the deepest attenuation
    acc(1'b1, 1'b0, 8'h2e, 9'h055);
    acc(1'b1, 1'b0, 8'h30, 9'h0ff);
    regReq = '0;
    @(negedge core_clk);
    cmp_out();
    foreach (addrs[i]) acc(1'b0, 1'b1, addrs[i], 9'h000);
    regReq = '0;
    rst_b = 1'b0;
    mdl_reset();
    @(negedge core_clk);
    cmp_out();
    rst_b = 1'b1;
    @(negedge core_clk);
    foreach (addrs[i]) acc(1'b0, 1'b1, addrs[i], 9'h000);
    regReq = '0;
    @(negedge core_clk);
    end_sim();
  end

  // hang guard: the sequence needs well under 1000 cycles
  initial begin
    #300000;
    fail("timeout");
    end_sim();
  end
endmodule

`default_nettype wire
